// ==== include/gcrc_consts.svh ====
// Register indices, field positions, codes and reset values of the
// checksum engine. Assumes it is included by its bare name.
`ifndef GCRC_CONSTS_SVH
`define GCRC_CONSTS_SVH

// Register indices; the APB byte address is four times the index.
`define GCRC_IDX_BREV    10'h096
`define GCRC_IDX_AUX     10'h0a2
`define GCRC_IDX_DATA    10'h0b6
`define GCRC_IDX_IAB     10'h0e4
`define GCRC_IDX_MODE    10'h0e5
`define GCRC_IDX_FAH     10'h0e6
`define GCRC_IDX_FAL     10'h0e7
`define GCRC_IDX_CMD     10'h0e8
`define GCRC_IDX_STAT    10'h0e9

// Field positions in the auxiliary control register.
`define GCRC_AUX_SEL_HI  5
`define GCRC_AUX_SEL_LO  4
`define GCRC_AUX_DPS     0

// Data port selector settings.
`define GCRC_SEL_SEED_LO 2'h0
`define GCRC_SEL_SEED_HI 2'h1
`define GCRC_SEL_RSVD    2'h2
`define GCRC_SEL_INPUT   2'h3

// Flash mode codes.
`define GCRC_MS_STANDBY  8'h00
`define GCRC_MS_READ     8'h01
`define GCRC_MS_PROG     8'h02
`define GCRC_MS_ERASE    8'h03
`define GCRC_MS_PWR      8'h04
`define GCRC_MS_PRD      8'h05
`define GCRC_MS_AUTO_CRC 8'h80
`define GCRC_MS_READ_INC 8'h81
`define GCRC_MS_PROG_INC 8'h82

// Checksum, unlock, flash run end and queue constants.
`define GCRC_POLY        16'h1021
`define GCRC_UNLOCK_A    8'h46
`define GCRC_UNLOCK_B    8'hb9
`define GCRC_BYTE_BITS   4'h8
`define GCRC_END_LOW     9'h1ff
`define GCRC_RST_BYTE    8'h00
`define GCRC_FIFO_WIDTH  8
`define GCRC_FIFO_DEPTH  8

`endif

// ==== include/gcrc_pkg.sv ====
// Types used by the checksum engine; its byte queue declares its own.
// Assumes nothing beyond a SystemVerilog compiler.
package gcrc_pkg;

  // Register selected by an APB address.
  typedef enum logic [3:0] {
    REG_NONE, REG_BREV, REG_AUX, REG_DATA, REG_IAB,
    REG_MODE, REG_FAH, REG_FAL, REG_CMD, REG_STAT
  } gcrc_reg_e;

  // Flash auto-read sequencer state.
  typedef enum logic {AR_IDLE, AR_RUN} gcrc_ar_e;

  // Decoded flash mode.
  typedef enum logic [3:0] {
    M_STANDBY, M_READ, M_PROG, M_ERASE, M_PWR, M_PRD,
    M_AUTO_CRC, M_READ_INC, M_PROG_INC, M_RSVD
  } gcrc_mode_e;

  // Whole state of the engine outside its byte queue.
  typedef struct packed {
    logic [7:0]  brev;
    logic [1:0]  sel;
    logic        data_pointer_select;
    logic [7:0]  mode;
    logic [7:0]  fah;
    logic [7:0]  fal;
    logic [6:0]  iab;
    logic        armed;
    gcrc_ar_e    ar;
    logic [15:0] addr;
    logic [15:0] crc;
    logic [7:0]  sh;
    logic [3:0]  bcnt;
    logic        idle_q;
    logic [31:0] prdata;
  } gcrc_state_s;

endpackage

// ==== verilog/gcrc_fifo.sv ====
// Byte queue in front of the checksum shifter.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none

module gcrc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,       // System clock.
  input  wire logic             rst_n,     // Asynchronous reset, low.
  input  wire logic             in_valid,  // Writer offers a word.
  output logic                  in_ready,  // Room for a word.
  input  wire logic [WIDTH-1:0] in_data,   // Word offered.
  output logic                  out_valid, // A word is waiting.
  input  wire logic             out_ready, // Reader takes the word.
  output logic      [WIDTH-1:0] out_data   // Oldest word.
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0]   cnt;
  } gcrc_fifo_s;

  gcrc_fifo_s       s;
  gcrc_fifo_s       next_s;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             push;
  logic             pop;

  ////////////////////////////////////////////////////////////////////////
  // Pointers wrap at DEPTH, so any depth works, not only powers of two.
  always_comb begin
    in_ready  = s.cnt != (AW+1)'(DEPTH);
    out_valid = s.cnt != '0;
    out_data  = mem[s.rd];
    push      = in_valid && in_ready;
    pop       = out_valid && out_ready;
    next_s    = s;
    if (push) begin
      next_s.wr = (s.wr == AW'(DEPTH - 1)) ? '0 : s.wr + 1'b1;
    end
    if (pop) begin
      next_s.rd = (s.rd == AW'(DEPTH - 1)) ? '0 : s.rd + 1'b1;
    end
    next_s.cnt = s.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  // Storage needs no reset; the count guards every read.
  always_ff @(posedge clk) begin
    if (push) begin
      mem[s.wr] <= in_data;
    end
  end

  // Pointer and count registers.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

endmodule

`default_nettype wire

// ==== verilog/gcrc_engine.sv ====
// CRC-16 engine with seed, multiplexed data port, flash auto-read
// feed and bit-order reversal, reached as an APB3 slave.
// Assumes one clock, APB signals synchronous to it, and a flash
// reader that answers each address request with one byte.
//
// Chosen here: the APB slave port.
`timescale 1ns/100ps
`default_nettype none
`include "gcrc_consts.svh"

module gcrc_engine (
  input  wire logic        pclk,            // System clock, 200 MHz.
  input  wire logic        presetn,         // Async reset, active low.
  input  wire logic        psel,            // APB select.
  input  wire logic        penable,         // APB access phase.
  input  wire logic        pwrite,          // APB write when high.
  input  wire logic [11:0] paddr,           // APB byte address.
  input  wire logic [31:0] pwdata,          // APB write data.
  output logic      [31:0] prdata,          // APB read data.
  output logic             pready,          // APB ready.
  output logic             pslverr,         // APB error, unmapped.
  output logic             flash_rd_req,    // Flash byte wanted.
  output logic      [15:0] flash_rd_addr,   // Flash byte address.
  input  wire logic        flash_rd_valid,  // Flash byte present.
  input  wire logic [7:0]  flash_rd_data,   // Flash byte.
  output logic             flash_rd_ready,  // Flash byte taken.
  output logic      [7:0]  flash_mode_code, // Mode register value.
  output logic             checksum_busy    // Engine not idle.
);

  gcrc_pkg::gcrc_state_s s;
  gcrc_pkg::gcrc_state_s next_s;
  gcrc_pkg::gcrc_reg_e   rid;
  logic [7:0]            brev_rd;
  logic [31:0]           rd;
  logic                  idle;
  logic                  done;
  logic                  cpu_in;
  logic                  fb;
  logic                  f_valid;
  logic                  f_ready;
  logic [7:0]            f_data;
  logic                  q_valid;
  logic                  q_ready;
  logic [7:0]            q_data;
  logic                  pop;
  logic [15:0]           end_addr;

  ////////////////////////////////////////////////////////////////////////
  // Address decode, shared by the bus logic and the checks.
  function automatic gcrc_pkg::gcrc_reg_e reg_of(input logic [11:0] a);
    case (a[11:2])
      `GCRC_IDX_BREV: reg_of = gcrc_pkg::REG_BREV;
      `GCRC_IDX_AUX:  reg_of = gcrc_pkg::REG_AUX;
      `GCRC_IDX_DATA: reg_of = gcrc_pkg::REG_DATA;
      `GCRC_IDX_IAB:  reg_of = gcrc_pkg::REG_IAB;
      `GCRC_IDX_MODE: reg_of = gcrc_pkg::REG_MODE;
      `GCRC_IDX_FAH:  reg_of = gcrc_pkg::REG_FAH;
      `GCRC_IDX_FAL:  reg_of = gcrc_pkg::REG_FAL;
      `GCRC_IDX_CMD:  reg_of = gcrc_pkg::REG_CMD;
      `GCRC_IDX_STAT: reg_of = gcrc_pkg::REG_STAT;
      default:        reg_of = gcrc_pkg::REG_NONE;
    endcase
  endfunction

  // Flash mode decode, used by the trigger and the status register.
  function automatic gcrc_pkg::gcrc_mode_e mode_of(input logic [7:0] m);
    case (m)
      `GCRC_MS_STANDBY:  mode_of = gcrc_pkg::M_STANDBY;
      `GCRC_MS_READ:     mode_of = gcrc_pkg::M_READ;
      `GCRC_MS_PROG:     mode_of = gcrc_pkg::M_PROG;
      `GCRC_MS_ERASE:    mode_of = gcrc_pkg::M_ERASE;
      `GCRC_MS_PWR:      mode_of = gcrc_pkg::M_PWR;
      `GCRC_MS_PRD:      mode_of = gcrc_pkg::M_PRD;
      `GCRC_MS_AUTO_CRC: mode_of = gcrc_pkg::M_AUTO_CRC;
      `GCRC_MS_READ_INC: mode_of = gcrc_pkg::M_READ_INC;
      `GCRC_MS_PROG_INC: mode_of = gcrc_pkg::M_PROG_INC;
      default:           mode_of = gcrc_pkg::M_RSVD;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // The reversal register stores the byte as written and mirrors it on
  // the way out.
  for (genvar i = 0; i < 8; i++) begin : g_rev
    assign brev_rd[i] = s.brev[7-i];
  end

  ////////////////////////////////////////////////////////////////////////
  // Every input byte, from software or flash, passes through the queue so
  // that a slow shifter pushes back on both sources.
  gcrc_fifo #(
    .WIDTH (`GCRC_FIFO_WIDTH),
    .DEPTH (`GCRC_FIFO_DEPTH)
  ) u_queue (
    .clk       (pclk),
    .rst_n     (presetn),
    .in_valid  (f_valid),
    .in_ready  (f_ready),
    .in_data   (f_data),
    .out_valid (q_valid),
    .out_ready (q_ready),
    .out_data  (q_data)
  );

  ////////////////////////////////////////////////////////////////////////
  // Bus handshake, queue feed, shifter, sequencer and register writes.
  always_comb begin
    next_s   = s;
    rid      = reg_of(paddr);
    end_addr = {s.iab, `GCRC_END_LOW};
    idle     = (s.bcnt == 4'h0) && !q_valid &&
               (s.ar == gcrc_pkg::AR_IDLE);
    cpu_in   = (rid == gcrc_pkg::REG_DATA) && pwrite &&
               (s.sel == `GCRC_SEL_INPUT);

    // Input writes wait for queue room and for the end of a flash run;
    // seed and result accesses wait until all queued bytes are folded
    // in, so a read never sees a half-updated checksum.
    pready = 1'b1;
    if (cpu_in) begin
      pready = f_ready && (s.ar == gcrc_pkg::AR_IDLE);
    end else if (rid == gcrc_pkg::REG_DATA && !s.sel[1]) begin
      pready = idle && s.idle_q;
    end
    done    = psel && penable && pready;
    pslverr = done && (rid == gcrc_pkg::REG_NONE);

    // Queue source: the flash reader while a run is active.
    flash_rd_req   = s.ar == gcrc_pkg::AR_RUN;
    flash_rd_ready = flash_rd_req && f_ready;
    if (flash_rd_req) begin
      f_valid = flash_rd_valid;
      f_data  = flash_rd_data;
    end else begin
      f_valid = done && pwrite && cpu_in;
      f_data  = pwdata[7:0];
    end

    // The shifter takes a byte only when the previous one is done.
    q_ready = s.bcnt == 4'h0;
    pop     = q_valid && q_ready;
    fb      = s.crc[15] ^ s.sh[7];
    if (s.bcnt != 4'h0) begin
      next_s.crc  = {s.crc[14:0], 1'b0} ^
                    (fb ? `GCRC_POLY : 16'h0000);
      next_s.sh   = {s.sh[6:0], 1'b0};
      next_s.bcnt = s.bcnt - 4'h1;
    end
    if (pop) begin
      next_s.sh   = q_data;
      next_s.bcnt = `GCRC_BYTE_BITS;
    end

    // Flash run walks up one address per accepted byte.
    if (flash_rd_ready && flash_rd_valid) begin
      if (s.addr == end_addr) begin
        next_s.ar = gcrc_pkg::AR_IDLE;
      end else begin
        next_s.addr = s.addr + 16'h0001;
      end
    end

    // Register writes take effect at the completing edge only.
    if (done && pwrite) begin
      case (rid)
        gcrc_pkg::REG_BREV: next_s.brev = pwdata[7:0];
        gcrc_pkg::REG_AUX: begin
          next_s.sel =
            pwdata[`GCRC_AUX_SEL_HI:`GCRC_AUX_SEL_LO];
          next_s.data_pointer_select = pwdata[`GCRC_AUX_DPS];
        end
        gcrc_pkg::REG_DATA: begin
          if (s.sel == `GCRC_SEL_SEED_LO) begin
            next_s.crc[7:0] = pwdata[7:0];
          end else if (s.sel == `GCRC_SEL_SEED_HI) begin
            next_s.crc[15:8] = pwdata[7:0];
          end
        end
        gcrc_pkg::REG_IAB:  next_s.iab = pwdata[6:0];
        gcrc_pkg::REG_MODE: next_s.mode = pwdata[7:0];
        gcrc_pkg::REG_FAH:  next_s.fah = pwdata[7:0];
        gcrc_pkg::REG_FAL:  next_s.fal = pwdata[7:0];
        gcrc_pkg::REG_CMD: begin
          // Any byte other than the first key disarms the sequence.
          next_s.armed = pwdata[7:0] == `GCRC_UNLOCK_A;
          if (s.armed && pwdata[7:0] == `GCRC_UNLOCK_B &&
              mode_of(s.mode) == gcrc_pkg::M_AUTO_CRC &&
              s.ar == gcrc_pkg::AR_IDLE) begin
            next_s.ar   = gcrc_pkg::AR_RUN;
            next_s.addr = {s.fah, s.fal};
          end
        end
        default: ;
      endcase
    end

    // Read data is formed every cycle from the current address and registered on each edge.
    rd = 32'h0000_0000;
    case (rid)
      gcrc_pkg::REG_BREV: rd[7:0] = brev_rd;
      gcrc_pkg::REG_AUX: begin
        rd[`GCRC_AUX_SEL_HI:`GCRC_AUX_SEL_LO] = s.sel;
        rd[`GCRC_AUX_DPS] = s.data_pointer_select;
      end
      gcrc_pkg::REG_DATA: begin
        if (s.sel == `GCRC_SEL_SEED_LO) begin
          rd[7:0] = s.crc[7:0];
        end else if (s.sel == `GCRC_SEL_SEED_HI) begin
          rd[7:0] = s.crc[15:8];
        end
      end
      gcrc_pkg::REG_IAB:  rd[6:0] = s.iab;
      gcrc_pkg::REG_MODE: rd[7:0] = s.mode;
      gcrc_pkg::REG_FAH:  rd[7:0] = s.fah;
      gcrc_pkg::REG_FAL:  rd[7:0] = s.fal;
      gcrc_pkg::REG_STAT: begin
        rd[0]   = !idle;
        rd[1]   = s.ar == gcrc_pkg::AR_RUN;
        rd[2]   = s.armed;
        rd[7:4] = mode_of(s.mode);
      end
      default: ;
    endcase
    next_s.prdata = rd;
    next_s.idle_q = idle;
  end

  // Outputs straight from the state register.
  assign prdata          = s.prdata;
  assign flash_rd_addr   = s.addr;
  assign flash_mode_code = s.mode;
  assign checksum_busy   = !s.idle_q;

  // State register; every field resets to zero.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks on the engine's own behaviour.
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic wr_done;
  logic rd_done;
  logic busy;
  assign wr_done = done && pwrite;
  assign rd_done = done && !pwrite;
  assign busy    = s.bcnt != 4'h0;

  a_poly_step: assert property (
    busy |=> s.crc == ($past(fb) ?
      ({$past(s.crc[14:0]), 1'b0} ^ `GCRC_POLY) :
      {$past(s.crc[14:0]), 1'b0}))
    else $error("checksum step does not follow the polynomial");

  a_byte_cycles: assert property (
    pop |=> busy [*8] ##1 !busy)
    else $error("byte not folded in eight cycles");

  a_input_push: assert property (
    wr_done && rid == gcrc_pkg::REG_DATA &&
    s.sel == `GCRC_SEL_INPUT |-> f_valid && f_ready)
    else $error("input byte not queued");

  a_seed_low: assert property (
    wr_done && rid == gcrc_pkg::REG_DATA &&
    s.sel == `GCRC_SEL_SEED_LO |=> s.crc[7:0] == $past(pwdata[7:0]))
    else $error("low seed not loaded");

  a_seed_high: assert property (
    wr_done && rid == gcrc_pkg::REG_DATA &&
    s.sel == `GCRC_SEL_SEED_HI |=> s.crc[15:8] == $past(pwdata[7:0]))
    else $error("high seed not loaded");

  a_result_read: assert property (
    rd_done && rid == gcrc_pkg::REG_DATA && !s.sel[1] |->
    prdata[7:0] == (s.sel[0] ? s.crc[15:8] : s.crc[7:0]))
    else $error("result byte read wrong");

  a_rsvd_read: assert property (
    rd_done && rid == gcrc_pkg::REG_DATA && s.sel[1] |->
    prdata == 32'h0000_0000)
    else $error("reserved selector read not zero");

  a_aux_sel: assert property (
    wr_done && rid == gcrc_pkg::REG_AUX |=>
    s.sel == $past(pwdata[5:4]))
    else $error("selector not written");

  a_unlock_start: assert property (
    s.ar == gcrc_pkg::AR_IDLE ##1 s.ar == gcrc_pkg::AR_RUN |->
    $past(s.armed) && $past(s.mode) == `GCRC_MS_AUTO_CRC &&
    $past(pwdata[7:0]) == `GCRC_UNLOCK_B)
    else $error("flash run started without unlock");

  a_last_addr: assert property (
    flash_rd_ready && flash_rd_valid &&
    flash_rd_addr == {s.iab, `GCRC_END_LOW} |=>
    s.ar == gcrc_pkg::AR_IDLE)
    else $error("flash run passed its last address");

  a_brev_read: assert property (
    rd_done && rid == gcrc_pkg::REG_BREV |->
    prdata[7] == s.brev[0] && prdata[0] == s.brev[7])
    else $error("reversed byte read wrong");

endmodule

`default_nettype wire

// ==== tb/gcrc_engine_tb_top.sv ====
// Self-checking bench for the checksum engine, driven over APB.
// Assumes the engine and its byte queue are compiled before this file.
`timescale 1ns/100ps
`default_nettype none
`include "gcrc_consts.svh"

module gcrc_engine_tb_top;
  logic        pclk           = 1'b0;
  logic        presetn        = 1'b0;
  logic        psel           = 1'b0;
  logic        penable        = 1'b0;
  logic        pwrite         = 1'b0;
  logic [11:0] paddr          = 12'h000;
  logic [31:0] pwdata         = 32'h00000000;
  logic        flash_rd_valid = 1'b0;
  logic [7:0]  flash_rd_data  = 8'h00;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        flash_rd_req;
  logic [15:0] flash_rd_addr;
  logic        flash_rd_ready;
  logic [7:0]  flash_mode_code;
  logic        checksum_busy;
  logic [31:0] rdata;
  logic        rerr;
  logic [15:0] exp_crc;
  logic [15:0] exp_addr;
  int          bad_count  = 0;
  int          n_compared = 0;
  int          got_n      = 0;
  int          refusals   = 0;

  localparam logic [7:0] RV_IN [4]  = '{8'ha0, 8'h01, 8'h3c, 8'hf1};
  localparam logic [7:0] RV_OUT [4] = '{8'h05, 8'h80, 8'h3c, 8'h8f};
  localparam logic [7:0] MS_IN [11] = '{8'h00, 8'h01, 8'h02, 8'h03,
    8'h04, 8'h05, 8'h80, 8'h81, 8'h82, 8'h06, 8'h83};
  localparam logic [3:0] MS_DEC [11] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4,
    4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'h9};

  gcrc_engine dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .flash_rd_req(flash_rd_req),
    .flash_rd_addr(flash_rd_addr), .flash_rd_valid(flash_rd_valid),
    .flash_rd_data(flash_rd_data), .flash_rd_ready(flash_rd_ready),
    .flash_mode_code(flash_mode_code), .checksum_busy(checksum_busy)
  );

  // The 200 MHz system clock.
  always #2.5 pclk = ~pclk;

  ////////////////////////////////////////////////////////////////////////
  // Checking and bus helpers.

  // Case inequality, so an unknown never passes for a match.
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic summarize();
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // One APB transfer; the request stands until pready is seen high.
  task automatic apb(input logic wr, input logic [9:0] idx,
                     input logic [7:0] wd, output logic [31:0] rd,
                     output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= {idx, 2'b00};
    pwdata <= {24'h000000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 2000);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 2000) begin
      bad_count++;
      $display("unexpected pready: expected 1, seen %b", pready);
      summarize();
    end
  endtask

  // Register write that must not be refused.
  task automatic wr(input logic [9:0] idx, input logic [7:0] v);
    apb(1'b1, idx, v, rdata, rerr);
    chk("write error", 32'h0, {31'h0, rerr});
  endtask

  // Register read compared with an expected byte.
  task automatic rd_chk(input logic [9:0] idx, input logic [7:0] v,
                        input string what);
    apb(1'b0, idx, 8'h00, rdata, rerr);
    chk(what, {24'h0, v}, rdata);
    chk("read error", 32'h0, {31'h0, rerr});
  endtask

  // Selector write; the data pointer bit stays clear.
  task automatic sel(input logic [1:0] s);
    wr(`GCRC_IDX_AUX, {2'b00, s, 4'h0});
  endtask

  // Bitwise model of the CCITT update, most significant bit first.
  function automatic logic [15:0] crc_step(input logic [15:0] c,
                                           input logic [7:0] b);
    logic fb;
    for (int i = 7; i >= 0; i--) begin
      fb = c[15] ^ b[i];
      c = {c[14:0], 1'b0} ^ (fb ? `GCRC_POLY : 16'h0000);
    end
    return c;
  endfunction

  // Waits, bounded, until the flash run has drained completely.
  task automatic wait_run(input int n_bytes);
    int n;
    n = 0;
    while (!(got_n == n_bytes && flash_rd_req === 1'b0 &&
             checksum_busy === 1'b0) && n < 3000) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 3000) begin
      bad_count++;
      $display("unexpected bytes: expected %0d, seen %0d", n_bytes, got_n);
      summarize();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Flash side: offers a byte every other cycle, so the engine also sees
  // gaps; a released data line is inverted so no stale byte survives.
  always @(posedge pclk) begin
    if (flash_rd_valid && flash_rd_ready === 1'b1 && flash_rd_req) begin
      chk("flash address", {16'h0, exp_addr}, {16'h0, flash_rd_addr});
      exp_crc = crc_step(exp_crc, flash_rd_data);
      exp_addr = exp_addr + 16'h0001;
      got_n++;
      flash_rd_valid <= 1'b0;
      flash_rd_data  <= ~flash_rd_data;
    end else if (flash_rd_req === 1'b1 && !flash_rd_valid) begin
      flash_rd_valid <= 1'b1;
      flash_rd_data  <= flash_rd_addr[7:0] ^ 8'h5a;
    end else if (flash_rd_req !== 1'b1) begin
      flash_rd_valid <= 1'b0;
    end
    if (flash_rd_req === 1'b1 && flash_rd_ready !== 1'b1) refusals++;
  end

  ////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(`GCRC_IDX_BREV, 8'h00, "reversal reset");
    rd_chk(`GCRC_IDX_AUX, 8'h00, "aux reset");
    rd_chk(`GCRC_IDX_DATA, 8'h00, "result low reset");
    rd_chk(`GCRC_IDX_MODE, 8'h00, "mode reset");
    apb(1'b0, 10'h001, 8'h00, rdata, rerr);
    chk("unmapped error", 32'h1, {31'h0, rerr});
    chk("unmapped data", 32'h0, rdata);
    // Mirror table, including a palindrome byte.
    for (int i = 0; i < 4; i++) begin
      wr(`GCRC_IDX_BREV, RV_IN[i]);
      rd_chk(`GCRC_IDX_BREV, RV_OUT[i], "bit reversal");
    end
    wr(`GCRC_IDX_AUX, 8'h31);
    rd_chk(`GCRC_IDX_AUX, 8'h31, "aux selector");
    // Seed halves read straight back as the result halves.
    sel(2'b00);
    wr(`GCRC_IDX_DATA, 8'h34);
    sel(2'b01);
    wr(`GCRC_IDX_DATA, 8'h12);
    rd_chk(`GCRC_IDX_DATA, 8'h12, "seed high");
    sel(2'b00);
    rd_chk(`GCRC_IDX_DATA, 8'h34, "seed low");
    // Back-to-back input bytes of the check string after an all-ones seed.
    wr(`GCRC_IDX_DATA, 8'hff);
    sel(2'b01);
    wr(`GCRC_IDX_DATA, 8'hff);
    sel(2'b11);
    exp_crc = 16'hffff;
    for (int i = 0; i < 9; i++) begin
      wr(`GCRC_IDX_DATA, 8'h31 + i[7:0]);
      exp_crc = crc_step(exp_crc, 8'h31 + i[7:0]);
    end
    // Queued bytes are still being folded in when the last write ends.
    chk("busy after input", 32'h1, {31'h0, checksum_busy});
    chk("model check", 32'h29b1, {16'h0, exp_crc});
    // Reserved selector: write lost, reads give zero.
    sel(2'b10);
    wr(`GCRC_IDX_DATA, 8'h55);
    rd_chk(`GCRC_IDX_DATA, 8'h00, "reserved read");
    sel(2'b11);
    rd_chk(`GCRC_IDX_DATA, 8'h00, "input read");
    sel(2'b00);
    rd_chk(`GCRC_IDX_DATA, exp_crc[7:0], "result low");
    sel(2'b01);
    rd_chk(`GCRC_IDX_DATA, exp_crc[15:8], "result high");
    // Every listed mode code and two reserved ones.
    for (int i = 0; i < 11; i++) begin
      wr(`GCRC_IDX_MODE, MS_IN[i]);
      rd_chk(`GCRC_IDX_MODE, MS_IN[i], "mode readback");
      chk("mode port", {24'h0, MS_IN[i]}, {24'h0, flash_mode_code});
      apb(1'b0, `GCRC_IDX_STAT, 8'h00, rdata, rerr);
      chk("decoded mode", {28'h0, MS_DEC[i]}, {28'h0, rdata[7:4]});
    end
    // Flash run over 0x03f4 to 0x03ff, first under a wrong mode code and
    // then with a broken unlock; neither may start it.
    sel(2'b00);
    wr(`GCRC_IDX_DATA, 8'hff);
    sel(2'b01);
    wr(`GCRC_IDX_DATA, 8'hff);
    sel(2'b11);
    wr(`GCRC_IDX_MODE, `GCRC_MS_READ_INC);
    wr(`GCRC_IDX_IAB, 8'h01);
    wr(`GCRC_IDX_FAH, 8'h03);
    wr(`GCRC_IDX_FAL, 8'hf4);
    exp_crc = 16'hffff;
    exp_addr = 16'h03f4;
    wr(`GCRC_IDX_CMD, `GCRC_UNLOCK_A);
    wr(`GCRC_IDX_CMD, `GCRC_UNLOCK_B);
    wr(`GCRC_IDX_MODE, `GCRC_MS_AUTO_CRC);
    wr(`GCRC_IDX_CMD, `GCRC_UNLOCK_A);
    wr(`GCRC_IDX_CMD, 8'h00);
    wr(`GCRC_IDX_CMD, `GCRC_UNLOCK_B);
    repeat (20) @(posedge pclk);
    chk("run without unlock", 32'h0, got_n);
    chk("request without unlock", 32'h0, {31'h0, flash_rd_req});
    wr(`GCRC_IDX_CMD, `GCRC_UNLOCK_A);
    wr(`GCRC_IDX_CMD, `GCRC_UNLOCK_B);
    wait_run(12);
    chk("run bytes", 32'd12, got_n);
    chk("queue refused", 32'h1, {31'h0, refusals > 0});
    repeat (5) @(posedge pclk);
    chk("request after run", 32'h0, {31'h0, flash_rd_req});
    sel(2'b00);
    rd_chk(`GCRC_IDX_DATA, exp_crc[7:0], "run result low");
    sel(2'b01);
    rd_chk(`GCRC_IDX_DATA, exp_crc[15:8], "run result high");
    summarize();
  end
endmodule

`default_nettype wire
